// ---- design/hwm_pkg.sv ----
// Purpose: shared constants and types of the monitor configuration block
// Assumes: 32-bit classic wishbone, 8-bit registers in the low byte lane
// Notes: register index times four gives the byte address
package hwm_pkg;

	// ----------------------------------------
	// register indices and byte addresses
	// ----------------------------------------
	localparam logic [7:0] IDX_VOLT_CODE = 8'h47;
	localparam logic [7:0] IDX_TEST_MODE = 8'h4A;
	localparam logic [7:0] IDX_TEST_VALUE = 8'h4C;
	localparam logic [7:0] IDX_SPECIAL = 8'h4F;
	localparam logic [7:0] IDX_IRQ_STATUS = 8'h60;
	localparam logic [7:0] IDX_IRQ_MASK = 8'h61;
	localparam int ADDR_W = 10;
	localparam logic [ADDR_W-1:0] ADDR_VOLT_CODE = {IDX_VOLT_CODE, 2'b00};
	localparam logic [ADDR_W-1:0] ADDR_TEST_MODE = {IDX_TEST_MODE, 2'b00};
	localparam logic [ADDR_W-1:0] ADDR_TEST_VALUE = {IDX_TEST_VALUE, 2'b00};
	localparam logic [ADDR_W-1:0] ADDR_SPECIAL = {IDX_SPECIAL, 2'b00};
	localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = {IDX_IRQ_STATUS, 2'b00};
	localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = {IDX_IRQ_MASK, 2'b00};

	// ----------------------------------------
	// field positions and reset values
	// ----------------------------------------
	localparam int SF_SHUTDOWN = 0;
	localparam int SF_CYCLED = 1;
	localparam int SF_ALARM_EN = 2;
	localparam int SF_VOLT_ALARM = 3;
	localparam int SF_OFS_INTERNAL = 4;
	localparam int SF_FAST_AVG = 5;
	localparam logic [7:0] SF_WRITABLE = 8'h3F;
	localparam int VC_RESET_OUT = 7;
	localparam int VC_CODE_W = 4;
	localparam int TM_DIGITAL = 1;
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam int IRQ_W = 3;
	localparam int IRQ_RESULT = 0;
	localparam int IRQ_ALARM = 1;
	localparam int IRQ_RST_DONE = 2;

	// ----------------------------------------
	// averaging figures
	// ----------------------------------------
	localparam int AVG_REMOTE_SLOW_LOG2 = 7;
	localparam int AVG_REMOTE_FAST_LOG2 = 4;
	localparam int AVG_OTHER_SLOW_LOG2 = 3;
	localparam int AVG_OTHER_FAST_LOG2 = 0;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_KHZ = 10000;
	localparam int RESET_PULSE_US = 1000;
	localparam int RESET_PULSE_CYC = (RESET_PULSE_US * CLK_KHZ) / 1000;

	// ----------------------------------------
	// carried types
	// ----------------------------------------
	typedef enum logic [1:0] {
		HWM_PIN_ADDR_IN,
		HWM_PIN_RESET_OUT,
		HWM_PIN_ALARM_OUT
	} hwm_pin_role_e;

	typedef struct packed {
		logic valid;
		logic remote;
		logic [3:0] chan;
		logic [7:0] data;
	} hwm_sample_s;

	typedef struct packed {
		logic valid;
		logic [3:0] chan;
		logic [7:0] data;
	} hwm_result_s;

endpackage

// ---- design/hwm_sync.sv ----
// Purpose: two-flop synchroniser for pin levels
// Assumes: inputs are quasi-static levels
// Notes: only the second stage is visible outside
`timescale 1ns/1ps
module hwm_sync #(
	parameter int W = 1
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	logic [W-1:0] meta;

	// ----------------------------------------
	// two stages, first stage read only by second
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			meta <= '0;
			q_o <= '0;
		end else begin
			meta <= d_i;
			q_o <= meta;
		end
	end
endmodule

// ---- design/hwm_avg.sv ----
// Purpose: per-channel averaging of converter samples
// Assumes: samples of one channel arrive back to back until its average is done
// Notes: a channel change restarts the accumulation
`timescale 1ns/1ps
module hwm_avg #(
	parameter int DW = 8
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic fast_i,
	input wire hwm_pkg::hwm_sample_s sample_i,
	output hwm_pkg::hwm_result_s result_o
);
	localparam int AW = DW + hwm_pkg::AVG_REMOTE_SLOW_LOG2 + 1;

	logic [AW-1:0] acc;
	logic [7:0] cnt;
	logic [3:0] cur_chan;
	wire [3:0] shift_w;
	wire [7:0] last_w;
	wire restart_w;
	wire [AW-1:0] sum_w;
	wire [AW-1:0] avg_w;

	// ----------------------------------------
	// pick sample count from channel kind and speed bit
	// ----------------------------------------
	function automatic logic [3:0] avg_log2(input logic remote, input logic fast);
		if (remote)
			avg_log2 = fast ? 4'(hwm_pkg::AVG_REMOTE_FAST_LOG2) : 4'(hwm_pkg::AVG_REMOTE_SLOW_LOG2);
		else
			avg_log2 = fast ? 4'(hwm_pkg::AVG_OTHER_FAST_LOG2) : 4'(hwm_pkg::AVG_OTHER_SLOW_LOG2);
	endfunction

	assign shift_w = avg_log2(sample_i.remote, fast_i);
	assign last_w = 8'((9'd1 << shift_w) - 9'd1);
	assign restart_w = (sample_i.chan != cur_chan) || (cnt == 8'h00);
	assign sum_w = (restart_w ? '0 : acc) + AW'(sample_i.data);
	assign avg_w = sum_w >> shift_w;

	// ----------------------------------------
	// accumulate, emit one result per full set
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			acc <= '0;
			cnt <= 8'h00;
			cur_chan <= 4'h0;
			result_o <= '0;
		end else begin
			result_o.valid <= 1'b0;
			if (sample_i.valid) begin
				cur_chan <= sample_i.chan;
				if ((restart_w ? 8'h00 : cnt) >= last_w) begin
					cnt <= 8'h00;
					acc <= '0;
					result_o.valid <= 1'b1;
					result_o.chan <= sample_i.chan;
					result_o.data <= avg_w[DW-1:0];
				end else begin
					cnt <= (restart_w ? 8'h00 : cnt) + 8'h01;
					acc <= sum_w;
				end
			end
		end
	end
endmodule

// ---- design/hwm_sfr.sv ----
// Purpose: special function and test value registers of the hardware monitor
// Assumes: limit comparators and converter run on clk_i; pins are asynchronous
// Notes: registers sit in the low byte of one word each
//
// Decided for this implementation: the Wishbone slave port.
`timescale 1ns/1ps
module hwm_sfr #(
	parameter int RESET_PULSE_CYC = hwm_pkg::RESET_PULSE_CYC
) (
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [hwm_pkg::ADDR_W-1:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	output logic irq_o,
	// converter side
	input wire hwm_pkg::hwm_sample_s sample_i,
	output hwm_pkg::hwm_result_s result_o,
	input wire logic temp_over_limit_i,
	input wire logic volt_over_limit_i,
	input wire logic reset_request_i,
	input wire logic [hwm_pkg::VC_CODE_W-1:0] processor_voltage_code_i,
	// mode outputs
	output logic shutdown_mode_o,
	output logic cycled_monitor_o,
	output logic offset_to_internal_o,
	output logic fast_average_o,
	output logic digital_test_o,
	output logic slave_addr_low_bit_o,
	// shared pin, open drain
	input wire logic shared_pin_i,
	output logic shared_pin_o,
	output logic shared_pin_oe_n_o
);
	localparam int PW = $clog2(RESET_PULSE_CYC + 1);

	logic [7:0] special;
	logic [7:0] test_value;
	logic [7:0] test_mode;
	logic reset_out_sel;
	logic [hwm_pkg::IRQ_W-1:0] irq_status;
	logic [hwm_pkg::IRQ_W-1:0] irq_mask;
	logic [PW-1:0] pulse_cnt;
	logic alarm_prev;
	logic [hwm_pkg::VC_CODE_W-1:0] code_sync;
	logic pin_sync;
	hwm_pkg::hwm_result_s avg_result;

	// ----------------------------------------
	// synchronise pin inputs
	// ----------------------------------------
	hwm_sync #(
		.W(hwm_pkg::VC_CODE_W + 1)
	) u_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.d_i({processor_voltage_code_i, shared_pin_i}),
		.q_o({code_sync, pin_sync})
	);

	// ----------------------------------------
	// averaging engine
	// ----------------------------------------
	hwm_avg #(
		.DW(8)
	) u_avg (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.fast_i(special[hwm_pkg::SF_FAST_AVG]),
		.sample_i(sample_i),
		.result_o(avg_result)
	);

	// ----------------------------------------
	// bus decode
	// ----------------------------------------
	wire req_w = cyc_i & stb_i & ~ack_o;
	wire wr_w = req_w & we_i & sel_i[0];
	wire rd_w = req_w & ~we_i;
	wire hit_special_w = (adr_i == hwm_pkg::ADDR_SPECIAL);
	wire hit_value_w = (adr_i == hwm_pkg::ADDR_TEST_VALUE);
	wire hit_mode_w = (adr_i == hwm_pkg::ADDR_TEST_MODE);
	wire hit_code_w = (adr_i == hwm_pkg::ADDR_VOLT_CODE);
	wire hit_stat_w = (adr_i == hwm_pkg::ADDR_IRQ_STATUS);
	wire hit_mask_w = (adr_i == hwm_pkg::ADDR_IRQ_MASK);

	// ----------------------------------------
	// alarm and pin role
	// ----------------------------------------
	wire alarm_active_w = temp_over_limit_i
		| (volt_over_limit_i & special[hwm_pkg::SF_VOLT_ALARM]);
	wire pulse_busy_w = (pulse_cnt != '0);
	hwm_pkg::hwm_pin_role_e pin_role_w;
	assign pin_role_w = special[hwm_pkg::SF_ALARM_EN] ? hwm_pkg::HWM_PIN_ALARM_OUT
		: (reset_out_sel ? hwm_pkg::HWM_PIN_RESET_OUT : hwm_pkg::HWM_PIN_ADDR_IN);

	logic next_drive_low;
	always_comb begin
		case (pin_role_w)
			hwm_pkg::HWM_PIN_ALARM_OUT: next_drive_low = alarm_active_w;
			hwm_pkg::HWM_PIN_RESET_OUT: next_drive_low = pulse_busy_w;
			hwm_pkg::HWM_PIN_ADDR_IN: next_drive_low = 1'b0;
			default: next_drive_low = 1'b0;
		endcase
	end

	// ----------------------------------------
	// read mux, reserved bits read zero
	// ----------------------------------------
	logic [7:0] next_rd;
	always_comb begin
		next_rd = 8'h00;
		if (hit_special_w)
			next_rd = special & hwm_pkg::SF_WRITABLE;
		else if (hit_value_w)
			next_rd = test_value;
		else if (hit_mode_w)
			next_rd = test_mode;
		else if (hit_code_w)
			next_rd = {reset_out_sel, 3'b000, code_sync};
		else if (hit_stat_w)
			next_rd = {5'b00000, irq_status};
		else if (hit_mask_w)
			next_rd = {5'b00000, irq_mask};
	end

	// ----------------------------------------
	// interrupt events; set beats read clear
	// ----------------------------------------
	wire [hwm_pkg::IRQ_W-1:0] events_w = {
		(pulse_cnt == PW'(1)),
		(alarm_active_w & ~alarm_prev),
		result_o.valid
	};
	wire stat_clear_w = rd_w & hit_stat_w;

	// ----------------------------------------
	// bus slave: one wait state, unmapped reads zero
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			dat_o <= 32'h0000_0000;
		end else begin
			ack_o <= req_w;
			dat_o <= rd_w ? {24'h00_0000, next_rd} : 32'h0000_0000;
		end
	end

	// ----------------------------------------
	// configuration registers
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			special <= hwm_pkg::REG_RESET;
			test_value <= hwm_pkg::REG_RESET;
			test_mode <= hwm_pkg::REG_RESET;
			reset_out_sel <= 1'b0;
			irq_mask <= '0;
		end else if (wr_w) begin
			if (hit_special_w)
				special <= dat_i[7:0] & hwm_pkg::SF_WRITABLE;
			if (hit_value_w)
				test_value <= dat_i[7:0];
			if (hit_mode_w)
				test_mode <= dat_i[7:0];
			if (hit_code_w)
				reset_out_sel <= dat_i[hwm_pkg::VC_RESET_OUT];
			if (hit_mask_w)
				irq_mask <= dat_i[hwm_pkg::IRQ_W-1:0];
		end
	end

	// ----------------------------------------
	// sticky status and interrupt line
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_status <= '0;
			irq_o <= 1'b0;
			alarm_prev <= 1'b0;
		end else begin
			irq_status <= (stat_clear_w ? '0 : irq_status) | events_w;
			irq_o <= |(((stat_clear_w ? '0 : irq_status) | events_w) & irq_mask);
			alarm_prev <= alarm_active_w;
		end
	end

	// ----------------------------------------
	// timed reset pulse; requests during a pulse are dropped
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i)
			pulse_cnt <= '0;
		else if (pulse_busy_w)
			pulse_cnt <= pulse_cnt - PW'(1);
		else if (reset_request_i && pin_role_w == hwm_pkg::HWM_PIN_RESET_OUT)
			pulse_cnt <= PW'(RESET_PULSE_CYC);
	end

	// ----------------------------------------
	// result path: test mode replaces the average
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			result_o <= '0;
		end else begin
			result_o <= avg_result;
			if (test_mode[hwm_pkg::TM_DIGITAL])
				result_o.data <= test_value;
		end
	end

	// ----------------------------------------
	// registered mode and pin outputs
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			shutdown_mode_o <= 1'b0;
			cycled_monitor_o <= 1'b0;
			offset_to_internal_o <= 1'b0;
			fast_average_o <= 1'b0;
			digital_test_o <= 1'b0;
			slave_addr_low_bit_o <= 1'b0;
			shared_pin_o <= 1'b0;
			shared_pin_oe_n_o <= 1'b1;
		end else begin
			shutdown_mode_o <= special[hwm_pkg::SF_SHUTDOWN];
			cycled_monitor_o <= special[hwm_pkg::SF_CYCLED];
			offset_to_internal_o <= special[hwm_pkg::SF_OFS_INTERNAL];
			fast_average_o <= special[hwm_pkg::SF_FAST_AVG];
			digital_test_o <= test_mode[hwm_pkg::TM_DIGITAL];
			// address bit holds its last value while the pin is an output
			if (pin_role_w == hwm_pkg::HWM_PIN_ADDR_IN)
				slave_addr_low_bit_o <= pin_sync;
			shared_pin_o <= 1'b0;
			shared_pin_oe_n_o <= ~next_drive_low;
		end
	end
endmodule

// ---- tb/hwm_sfr_checker.sv ----
// Purpose: port-level checks of the monitor config registers
// Assumes: single-cycle wishbone master, one clock domain
// Notes: shadow copies of two registers predict reads and the pin
`timescale 1ns/1ps
module hwm_sfr_checker (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [hwm_pkg::ADDR_W-1:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	input wire logic [31:0] dat_o,
	input wire logic ack_o,
	input wire hwm_pkg::hwm_sample_s sample_i,
	input wire hwm_pkg::hwm_result_s result_o,
	input wire logic temp_over_limit_i,
	input wire logic volt_over_limit_i,
	input wire logic shutdown_mode_o,
	input wire logic cycled_monitor_o,
	input wire logic offset_to_internal_o,
	input wire logic fast_average_o,
	input wire logic shared_pin_oe_n_o
);
	// ----------------------------------------
	// shadows and properties
	// ----------------------------------------
	logic [7:0] sf;
	logic [7:0] tv;
	// bus decode; wr marks the ack cycle of a write
	wire logic wr = cyc_i & stb_i & ack_o & we_i & sel_i[0];
	// the register itself changes on the edge that takes the request
	wire logic take = cyc_i & stb_i & !ack_o & we_i & sel_i[0];
	wire logic rd = cyc_i & stb_i & ack_o & !we_i;
	wire logic at_sf = adr_i == hwm_pkg::ADDR_SPECIAL;
	wire logic at_tv = adr_i == hwm_pkg::ADDR_TEST_VALUE;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// shadow copies, updated on the take edge so they never lag the design
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sf <= 8'h00;
			tv <= 8'h00;
		end else begin
			if (take && at_sf) sf <= dat_i[7:0];
			if (take && at_tv) tv <= dat_i[7:0];
		end
	end
	a_ack_one_pulse: assert property (ack_o |=> !ack_o)
		else $error("ack longer than one cycle");
	a_ack_next_cycle: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
		else $error("no ack one cycle after request");
	a_sf_readback: assert property (rd && at_sf |-> dat_o == {26'h000_0000, sf[5:0]})
		else $error("special read mismatch");
	a_tv_readback: assert property (rd && at_tv |-> dat_o == {24'h00_0000, tv})
		else $error("test value read mismatch");
	a_shutdown_follow: assert property (wr && at_sf |=> ##1 shutdown_mode_o == $past(dat_i[0], 2))
		else $error("shutdown output off");
	a_cycled_follow: assert property (wr && at_sf |=> ##1 cycled_monitor_o == $past(dat_i[1], 2))
		else $error("cycled output off");
	a_avg_route: assert property (wr && at_sf |=> ##1 {fast_average_o, offset_to_internal_o} == $past(dat_i[5:4], 2))
		else $error("offset or averaging output off");
	// pulls the pin two ways; reset history is excluded
	a_alarm_pin: assert property (!$past(rst_i) && $past(sf[2]) |-> shared_pin_oe_n_o ==
		!($past(temp_over_limit_i) || ($past(volt_over_limit_i) && $past(sf[3]))))
		else $error("alarm pin level wrong");
	a_single_result: assert property (sample_i.valid && !sample_i.remote && fast_average_o |-> ##2 result_o.valid)
		else $error("unaveraged result missing");
endmodule
bind hwm_sfr hwm_sfr_checker hwm_sfr_checker_i (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i,
	.dat_o, .ack_o, .sample_i, .result_o, .temp_over_limit_i, .volt_over_limit_i, .shutdown_mode_o,
	.cycled_monitor_o, .offset_to_internal_o, .fast_average_o, .shared_pin_oe_n_o);

// ---- tb/hwm_sfr_tb.sv ----
// Purpose: self-checking bench of the monitor config registers
// Assumes: reset pulse length shortened to 8 cycles
// Notes: open-drain pin level resolved here, released pin shows pin_lvl
`timescale 1ns/1ps
module hwm_sfr_tb;
	// ----------------------------------------
	// signals and design
	// ----------------------------------------
	localparam int PULSE = 8;
	localparam logic [9:0] SF = hwm_pkg::ADDR_SPECIAL;
	localparam logic [9:0] TV = hwm_pkg::ADDR_TEST_VALUE;
	localparam logic [9:0] TM = hwm_pkg::ADDR_TEST_MODE;
	localparam logic [9:0] VC = hwm_pkg::ADDR_VOLT_CODE;
	localparam logic [9:0] ST = hwm_pkg::ADDR_IRQ_STATUS;
	localparam logic [9:0] MK = hwm_pkg::ADDR_IRQ_MASK;
	logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, irq_o, temp, volt, reset_request_i;
	logic shutdown_mode_o, cycled_monitor_o, offset_to_internal_o, fast_average_o, digital_test_o;
	logic slave_addr_low_bit_o, shared_pin_o, oe_n, pin_lvl;
	logic [9:0] adr_i;
	logic [3:0] sel_i, code;
	logic [31:0] dat_i, dat_o;
	logic [7:0] q, rdat;
	hwm_pkg::hwm_sample_s sample_i;
	hwm_pkg::hwm_result_s result_o;
	int fails, checks_done, cyc_cnt, nres;
	// open drain: released pin shows the pull level
	wire logic shared_pin_i = oe_n ? pin_lvl : shared_pin_o;
	hwm_sfr #(.RESET_PULSE_CYC(PULSE)) hwm_sfr_i (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i,
		.dat_i, .dat_o, .ack_o, .irq_o, .sample_i, .result_o, .temp_over_limit_i(temp),
		.volt_over_limit_i(volt), .reset_request_i, .processor_voltage_code_i(code), .shutdown_mode_o,
		.cycled_monitor_o, .offset_to_internal_o, .fast_average_o, .digital_test_o, .slave_addr_low_bit_o,
		.shared_pin_i, .shared_pin_o, .shared_pin_oe_n_o(oe_n));
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task stop_test;
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task tick(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	// one classic cycle; entered just after an edge
	task wb(input logic w, input logic [9:0] a, input logic [7:0] d, output logic [7:0] r);
		int n;
		n = 0;
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= {24'h00_0000, d};
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1 && n < 20);
		r = dat_o[7:0];
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		@(posedge clk_i);
		if (n >= 20) fails++;
	endtask
	// n samples back to back, then expect exactly one result
	task avg(input logic r, input int n, input logic [7:0] d, input logic [7:0] e);
		nres = 0;
		repeat (n) begin
			sample_i <= {1'b1, r, 4'h1, d};
			@(posedge clk_i);
		end
		sample_i <= {1'b0, r, 4'h1, d};
		tick(4);
		chk("result count", 8'h01, nres[7:0]);
		chk("result data", e, rdat);
	endtask
	always @(posedge clk_i) begin
		if (result_o.valid === 1'b1) begin
			nres++;
			rdat = result_o.data;
		end
	end
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task t_reset;
		wb(1'b0, TV, 8'h00, q);
		chk("test value", 8'h00, q);
		wb(1'b0, SF, 8'h00, q);
		chk("special", 8'h00, q);
		chk("modes", 8'h00, {4'h0, fast_average_o, offset_to_internal_o, cycled_monitor_o, shutdown_mode_o});
		$display("done reset");
	endtask
	task t_special;
		logic [7:0] e;
		for (int k = 0; k < 8; k++) begin
			e = 8'h01 << k;
			wb(1'b1, SF, e, q);
			wb(1'b0, SF, 8'h00, q);
			e = e & 8'h3f;
			chk("special", e, q);
			chk("modes", {4'h0, e[5:4], e[1:0]},
				{4'h0, fast_average_o, offset_to_internal_o, cycled_monitor_o, shutdown_mode_o});
		end
		$display("done special");
	endtask
	task t_testval;
		wb(1'b1, TV, 8'ha5, q);
		wb(1'b0, TV, 8'h00, q);
		chk("test value", 8'ha5, q);
		wb(1'b1, 10'h3fc, 8'h5a, q);
		wb(1'b0, 10'h3fc, 8'h00, q);
		chk("unmapped", 8'h00, q);
		wb(1'b0, TV, 8'h00, q);
		chk("test value", 8'ha5, q);
		$display("done test value");
	endtask
	task t_pin;
		int n;
		wb(1'b1, SF, 8'h04, q);
		temp <= 1'b1;
		tick(2);
		chk("alarm temp", 8'h00, {7'h00, oe_n});
		temp <= 1'b0;
		volt <= 1'b1;
		tick(2);
		chk("volt ignored", 8'h01, {7'h00, oe_n});
		wb(1'b1, SF, 8'h0c, q);
		tick(1);
		chk("volt alarm", 8'h00, {7'h00, oe_n});
		volt <= 1'b0;
		wb(1'b1, SF, 8'h00, q);
		wb(1'b1, VC, 8'h80, q);
		reset_request_i <= 1'b1;
		tick(1);
		reset_request_i <= 1'b0;
		n = 0;
		repeat (20) begin
			@(posedge clk_i);
			if (oe_n === 1'b0) n++;
		end
		chk("pulse length", PULSE[7:0], n[7:0]);
		wb(1'b1, VC, 8'h00, q);
		pin_lvl <= 1'b0;
		tick(4);
		chk("address bit", 8'h00, {7'h00, slave_addr_low_bit_o});
		pin_lvl <= 1'b1;
		tick(4);
		chk("address bit", 8'h01, {7'h00, slave_addr_low_bit_o});
		$display("done pin");
	endtask
	task t_avg;
		wb(1'b1, SF, 8'h20, q);
		avg(1'b0, 1, 8'h3c, 8'h3c);
		avg(1'b1, 16, 8'h5b, 8'h5b);
		wb(1'b1, SF, 8'h00, q);
		avg(1'b0, 8, 8'h21, 8'h21);
		avg(1'b1, 128, 8'h96, 8'h96);
		wb(1'b1, TM, 8'h02, q);
		tick(1);
		chk("test mode", 8'h01, {7'h00, digital_test_o});
		avg(1'b0, 8, 8'h21, 8'ha5);
		wb(1'b1, TM, 8'h00, q);
		$display("done averaging");
	endtask
	task t_irq;
		wb(1'b1, MK, 8'h00, q);
		wb(1'b0, ST, 8'h00, q);
		avg(1'b0, 8, 8'h11, 8'h11);
		chk("irq masked", 8'h00, {7'h00, irq_o});
		wb(1'b1, MK, 8'h01, q);
		tick(2);
		chk("irq raised", 8'h01, {7'h00, irq_o});
		wb(1'b0, ST, 8'h00, q);
		chk("status", 8'h01, q & 8'h01);
		tick(2);
		chk("irq cleared", 8'h00, {7'h00, irq_o});
		$display("done interrupt");
	endtask
	// ----------------------------------------
	// clock, timeout and main sequence
	// ----------------------------------------
	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end
	// well above the few hundred cycles the run needs
	always @(posedge clk_i) begin
		cyc_cnt++;
		if (cyc_cnt == 3000) begin
			fails++;
			stop_test;
		end
	end
	initial begin
		{rst_i, pin_lvl, sel_i} = 6'h3f;
		{cyc_i, stb_i, we_i, temp, volt, reset_request_i} = 6'h00;
		{adr_i, dat_i, sample_i, code} = '0;
		code = 4'h5;
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		t_reset;
		t_special;
		t_testval;
		t_pin;
		t_avg;
		t_irq;
		stop_test;
	end
endmodule
